// *** design/pixcomp_map.svh ***
`ifndef PIXCOMP_MAP_SVH
`define PIXCOMP_MAP_SVH
`define REG_CTRL          8'h00
`define REG_DEFC          8'h04
`define REG_STAT          8'h08
`define CTRL_COMP         0
`define CTRL_VBM          1
`define CTRL_PART         3:2
`define CTRL_HOLD         4
`define CTRL_BYTE         5
`define CTRL_MODE         7:6
`define CTRL_CHANNEL_SELECT         9:8
`define CTRL_DEFO         10
`define CTRL_DEFG         11
`define CTRL_CDS          12
`define CTRL_MASK         32'h0000_1fff
`define CTRL_RST          32'h0000_1000
`define DEFC_OFF          5:0
`define DEFC_GAIN         27:16
`define DEFC_MASK         32'h0fff_003f
`define DEFC_RST          32'h0800_0000
`define FULL_SCALE        10'h3ff
`define SLOT_START        3'h4
`define LAT_COLOUR_HALF   41
`define COEF_COLOUR_HALF  31
`define LAT_FAST_HALF     59
`define COEF_FAST_HALF    45
`endif

// *** design/pixcomp_pkg.sv ***
package pixcomp_pkg;
   typedef enum logic [1:0] {
      MODE_COLOUR = 2'h0,
      MODE_MONO   = 2'h1,
      MODE_FAST   = 2'h3
   } mode_t;
   typedef struct packed {
      logic [11:0]       gain;
      logic signed [5:0] off;
      logic              dv;
   } coef_t;
   typedef struct packed {
      logic        v;
      logic [1:0]  ch;
      logic [15:0] w;
   } slot_t;
endpackage

// *** design/pixel_compensation_output_path.sv ***
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "pixcomp_map.svh"
module pixel_compensation_output_path
   import pixcomp_pkg::*;
#(
   parameter int PIPE_LEN = 32
) (
   input  wire logic        ref_clk,            // Master sample clock
   input  wire logic        rst_n,              // Sync reset
   input  wire logic [7:0]  s_axi_awaddr,       // Write address
   input  wire logic        s_axi_awvalid,      // Write address valid
   output      logic        s_axi_awready,      // Write address ready
   input  wire logic [31:0] s_axi_wdata,        // Write data
   input  wire logic [3:0]  s_axi_wstrb,        // Byte enables
   input  wire logic        s_axi_wvalid,       // Write data valid
   output      logic        s_axi_wready,       // Write data ready
   output      logic [1:0]  s_axi_bresp,        // Write response
   output      logic        s_axi_bvalid,       // Write response valid
   input  wire logic        s_axi_bready,       // Write response ready
   input  wire logic [7:0]  s_axi_araddr,       // Read address
   input  wire logic        s_axi_arvalid,      // Read address valid
   output      logic        s_axi_arready,      // Read address ready
   output      logic [31:0] s_axi_rdata,        // Read data
   output      logic [1:0]  s_axi_rresp,        // Read response
   output      logic        s_axi_rvalid,       // Read data valid
   input  wire logic        s_axi_rready,       // Read data ready
   input  wire logic [9:0]  converter_result,   // Converter word
   input  wire logic        video_sample_pulse, // Sample pulse pin
   input  wire logic [7:0]  coeff_in_bus,       // Coefficient bytes
   output      logic        conv_strobe,        // Conversion slot
   output      logic [1:0]  conv_channel,       // Mux channel
   output      logic [2:0]  coeff_addr_out,     // Coefficient RAM addr
   output      logic [9:0]  pixel_out_bus,      // Pixel output
   output      logic        pixel_valid_strobe, // Pixel valid
   output      logic        out_of_range_flag,  // Saturation flag
   output      logic        cds_enable          // CDS control
);
   localparam int LAT_C  = `LAT_COLOUR_HALF / 2;
   localparam int LAT_F  = `LAT_FAST_HALF / 2;
   localparam int COEF_C = `COEF_COLOUR_HALF / 2;
   localparam int COEF_F = `COEF_FAST_HALF / 2;
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `REG_CTRL) || (a == `REG_DEFC) || (a == `REG_STAT);
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) merge[8*b +: 8] = nw[8*b +: 8];
      end
   endfunction
   // Gain is widened to twelve bits so one multiplier serves all
   function automatic coef_t split(input logic [15:0] w,
                                   input logic [1:0]  part,
                                   input logic        vbm);
      unique case ({vbm, part})
         3'h1:    split = {w[15:5], 1'b0, 6'($signed(w[4:0])), 1'b0};
         3'h2:    split = {w[15:6], 2'h0, 6'($signed(w[5:0])), 1'b0};
         3'h5:    split = {w[15:6], 2'h0, 6'($signed(w[4:0])), w[5]};
         3'h4, 3'h6, 3'h7:
                  split = {w[15:5], 1'b0, 6'($signed(w[3:0])), w[4]};
         default: split = {w[15:4], 6'($signed(w[3:0])), 1'b0};
      endcase
   endfunction
   logic [31:0] ctrl_q;
   logic [31:0] defc_q;
   logic        is_fast;
   logic        is_mono;
   assign is_fast    = (ctrl_q[`CTRL_MODE] == MODE_FAST);
   assign is_mono    = (ctrl_q[`CTRL_MODE] != MODE_COLOUR);
   assign cds_enable = ctrl_q[`CTRL_CDS];
   // Register slave; one write and one read in flight
   logic        aw_have_q;
   logic        w_have_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        do_wr;
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_wr         = aw_have_q && w_have_q && !s_axi_bvalid;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         aw_have_q <= 1'b0;
         awaddr_q  <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_have_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         w_have_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (do_wr) begin
         w_have_q <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(awaddr_q) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= `CTRL_RST;
         defc_q <= `DEFC_RST;
      end else if (do_wr && awaddr_q == `REG_CTRL) begin
         ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & `CTRL_MASK;
      end else if (do_wr && awaddr_q == `REG_DEFC) begin
         defc_q <= merge(defc_q, wdata_q, wstrb_q) & `DEFC_MASK;
      end
   end
   logic [9:0] pix_q;
   logic       out_of_range_flag_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
         unique case (s_axi_araddr)
            `REG_CTRL: s_axi_rdata <= ctrl_q;
            `REG_DEFC: s_axi_rdata <= defc_q;
            `REG_STAT: s_axi_rdata <= {19'h0, conv_channel, out_of_range_flag_q, pix_q};
            default:   s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // Pins are asynchronous to the master clock
   logic       vs_s1_q;
   logic       vs_s2_q;
   logic       vs_s3_q;
   logic [7:0] cd_s1_q;
   logic [7:0] cd_s2_q;
   logic       vs_edge;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         vs_s1_q <= 1'b0;
         vs_s2_q <= 1'b0;
         vs_s3_q <= 1'b0;
         cd_s1_q <= 8'h00;
         cd_s2_q <= 8'h00;
      end else begin
         vs_s1_q <= video_sample_pulse;
         vs_s2_q <= vs_s1_q;
         vs_s3_q <= vs_s2_q;
         cd_s1_q <= coeff_in_bus;
         cd_s2_q <= cd_s1_q;
      end
   end
   assign vs_edge = vs_s2_q && !vs_s3_q;
   // Three slots two clocks apart per pulse; one slot in fast mono
   logic [2:0] cnt_q;
   logic       slot;
   logic [1:0] slot_ch;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) cnt_q <= 3'h0;
      else if (vs_edge && !is_fast) cnt_q <= `SLOT_START;
      else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
   end
   assign slot = vs_edge || cnt_q == 3'h3 || cnt_q == 3'h1;
   always_comb begin
      if (is_mono) slot_ch = ctrl_q[`CTRL_CHANNEL_SELECT];
      else if (vs_edge) slot_ch = 2'h0;
      else if (cnt_q == 3'h3) slot_ch = 2'h1;
      else slot_ch = 2'h2;
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         conv_strobe  <= 1'b0;
         conv_channel <= 2'h0;
      end else begin
         conv_strobe  <= slot;
         conv_channel <= slot_ch;
      end
   end
   // Each slot travels with its channel and gathers its coefficient
   slot_t pipe_q [PIPE_LEN];
   int    coef_tap;
   int    out_tap;
   assign coef_tap = (is_fast ? COEF_F : COEF_C) + 1;
   assign out_tap  = (is_fast ? LAT_F : LAT_C) - 2;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < PIPE_LEN; i++) pipe_q[i] <= '0;
      end else begin
         pipe_q[0] <= '{v: conv_strobe, ch: conv_channel, w: 16'h0000};
         for (int i = 1; i < PIPE_LEN; i++) begin
            pipe_q[i] <= pipe_q[i-1];
            if (i - 1 == coef_tap)
               pipe_q[i].w[15:8] <= cd_s2_q;
            if (i - 1 == coef_tap + 1)
               pipe_q[i].w[7:0] <= cd_s2_q;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) coeff_addr_out <= 3'h0;
      else if (pipe_q[coef_tap - 3].v)
         coeff_addr_out <= {pipe_q[coef_tap - 3].ch, 1'b0};
      else if (pipe_q[coef_tap - 2].v)
         coeff_addr_out <= {pipe_q[coef_tap - 2].ch, 1'b1};
   end
   // Arithmetic on the slot leaving the pipeline
   logic               fire;
   logic               comp;
   coef_t              cf;
   logic signed [5:0]  off;
   logic [11:0]        gain;
   logic signed [11:0] sum;
   logic [9:0]         sum_sat;
   logic               ovf_a;
   logic [21:0]        prod;
   logic [10:0]        scaled;
   logic [9:0]         res;
   logic               flag;
   logic               strobe_d;
   logic               upd;
   assign fire = pipe_q[out_tap].v;
   assign comp = ctrl_q[`CTRL_COMP];
   assign cf   = split(pipe_q[out_tap].w, ctrl_q[`CTRL_PART],
                       ctrl_q[`CTRL_VBM]);
   assign off  = ctrl_q[`CTRL_DEFO] ? $signed(defc_q[`DEFC_OFF]) : cf.off;
   assign gain = ctrl_q[`CTRL_DEFG] ? defc_q[`DEFC_GAIN] : cf.gain;
   assign sum  = $signed({2'h0, converter_result}) + 12'(off);
   assign ovf_a = sum < 0 || sum > $signed({2'h0, `FULL_SCALE});
   always_comb begin
      if (sum < 0) sum_sat = 10'h000;
      else if (ovf_a) sum_sat = `FULL_SCALE;
      else sum_sat = sum[9:0];
   end
   assign prod   = 22'(sum_sat) * 22'(gain);
   assign scaled = prod[21:11];
   always_comb begin
      if (!comp) begin
         res  = converter_result;
         flag = 1'b0;
      end else if (scaled > 11'(`FULL_SCALE)) begin
         res  = `FULL_SCALE;
         flag = 1'b1;
      end else begin
         res  = scaled[9:0];
         flag = ovf_a;
      end
   end
   assign strobe_d = fire && (!comp || !ctrl_q[`CTRL_VBM] || cf.dv);
   assign upd      = fire && (!ctrl_q[`CTRL_HOLD] || strobe_d);
   logic second_q;
   logic out_evt_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pix_q  <= 10'h000;
         out_of_range_flag_q <= 1'b0;
      end else if (upd) begin
         pix_q  <= res;
         out_of_range_flag_q <= flag;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pixel_out_bus      <= 10'h000;
         out_of_range_flag  <= 1'b0;
         pixel_valid_strobe <= 1'b0;
         second_q           <= 1'b0;
         out_evt_q          <= 1'b0;
      end else begin
         pixel_valid_strobe <= strobe_d;
         second_q           <= upd && ctrl_q[`CTRL_BYTE];
         out_evt_q          <= fire;
         if (upd) begin
            out_of_range_flag <= flag;
            if (ctrl_q[`CTRL_BYTE])
               pixel_out_bus <= {res[9:2], 2'h0};
            else
               pixel_out_bus <= res;
         end else if (second_q) begin
            pixel_out_bus <= {pix_q[1:0], 5'h00, out_of_range_flag_q, 2'h0};
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_pass_through: assert property (
      fire && !comp && !ctrl_q[`CTRL_BYTE] |=>
      pixel_out_bus == $past(converter_result) && !out_of_range_flag)
      else $error("Uncompensated pixel altered");
   chk_unity_gain: assert property (
      upd && comp && gain == 12'h800 && !ctrl_q[`CTRL_BYTE] |=>
      pixel_out_bus == $past(sum_sat))
      else $error("Unity gain changed the sum");
   chk_sat_flag: assert property (
      upd && comp && ovf_a |=> out_of_range_flag)
      else $error("Saturation not flagged");
   chk_dv_gate: assert property (
      fire && comp && ctrl_q[`CTRL_VBM] && !cf.dv |=> !pixel_valid_strobe)
      else $error("Strobe for unflagged pixel");
   chk_hold_output: assert property (
      ctrl_q[`CTRL_HOLD] && !ctrl_q[`CTRL_BYTE] && !strobe_d |=>
      $stable(pixel_out_bus))
      else $error("Held output moved");
   chk_byte_pair: assert property (
      upd && ctrl_q[`CTRL_BYTE] |=> pixel_out_bus[1:0] == 2'h0
      ##1 pixel_out_bus[2] == out_of_range_flag)
      else $error("Byte pair malformed");
   chk_colour_slots: assert property (
      vs_edge && ctrl_q[`CTRL_MODE] == MODE_COLOUR |->
      ##1 conv_strobe ##2 conv_strobe ##2 conv_strobe)
      else $error("Colour slots missing");
   chk_colour_latency: assert property (
      conv_strobe && ctrl_q[`CTRL_MODE] == MODE_COLOUR
      && $stable(ctrl_q) |-> ##20 out_evt_q)
      else $error("Colour latency wrong");
   chk_fast_latency: assert property (
      conv_strobe && is_fast && $stable(ctrl_q) |-> ##29 out_evt_q)
      else $error("Fast mono latency wrong");
   chk_mono_addr: assert property (
      is_mono && $stable(ctrl_q) && pipe_q[coef_tap - 3].v |=>
      coeff_addr_out[2:1] == ctrl_q[`CTRL_CHANNEL_SELECT])
      else $error("Mono channel not on address");
   chk_reset_mode: assert property (
      $rose(rst_n) |-> ctrl_q[`CTRL_MODE] == MODE_COLOUR && cds_enable)
      else $error("Reset mode not colour with CDS");
endmodule

// *** testbench/coef_source.sv ***
`timescale 1ns/1ps
module coef_source (
   input  wire logic [2:0]  coeff_addr_out, // Address from block
   input  wire logic [15:0] word0,          // Coefficient word, channel 0
   input  wire logic [15:0] word1,          // Coefficient word, channel 1
   input  wire logic [15:0] word2,          // Coefficient word, channel 2
   output      logic [7:0]  coeff_in_bus    // Byte to block
);
   logic [15:0] w;
   // Asynchronous RAM, so the byte is ready in the addressed cycle
   always_comb begin
      case (coeff_addr_out[2:1])
         2'h0: w = word0;
         2'h1: w = word1;
         2'h2: w = word2;
         default: w = ~word0;
      endcase
      coeff_in_bus = coeff_addr_out[0] ? w[7:0]
                                       : w[15:8];
   end
endmodule

// *** testbench/pixel_compensation_output_path_test.sv ***
`timescale 1ns/1ps
module pixel_compensation_output_path_test;
   logic        ref_clk = 1'b0, rst_n = 1'b0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, video_sample_pulse = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, conv_strobe;
   logic [1:0]  s_axi_bresp, s_axi_rresp, conv_channel;
   logic [9:0]  converter_result = '0, pixel_out_bus;
   logic [7:0]  coeff_in_bus;
   logic [2:0]  coeff_addr_out;
   logic        pixel_valid_strobe, out_of_range_flag, cds_enable;
   logic [15:0] word [3] = '{16'h0, 16'h0, 16'h0};
   logic [15:0] rs = 16'd62;
   logic [11:0] ev;
   logic [31:0] ctl = 32'h1000, defc = 32'h0800_0000;
   int          n_errors = 0, comparisons = 0, cycles = 0, i, j;
   int          tadc [10] = '{512, 512, 512, 1022, 1022, 512, 512, 512, 511, 3};
   int          tpoc [10] = '{0, -7, 6, 6, 6, 0, 0, 0, 0, -8};
   int          tpsc [10] = '{2048, 2048, 2048, 2048, 512, 2560, 512, 4095,
                              4095, 2048};
   int          sels [5] = '{0, 1, 2, 4, 5};

   pixel_compensation_output_path pixel_compensation_output_path_i (
      .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .converter_result, .video_sample_pulse,
      .coeff_in_bus, .conv_strobe, .conv_channel, .coeff_addr_out,
      .pixel_out_bus, .pixel_valid_strobe, .out_of_range_flag, .cds_enable);
   coef_source coef_source_i (.coeff_addr_out, .word0(word[0]),
      .word1(word[1]), .word2(word[2]), .coeff_in_bus);

   always #4 ref_clk = ~ref_clk;

   function automatic logic [15:0] rnd();
      rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
      return rs;
   endfunction

   // Returns {strobe wanted, flag, pixel}
   function automatic logic [11:0] model(input logic [9:0] a,
                                         input logic [15:0] w);
      int s, gw, ow, g, o, p;
      logic f, dv;
      logic [2:0] sel;
      sel = {ctl[1], ctl[3:2]};
      if (!ctl[0]) return {2'b10, a};
      gw = (sel == 1 || sel == 4) ? 11 : (sel == 2 || sel == 5) ? 10 : 12;
      ow = (sel == 1 || sel == 5) ? 5 : (sel == 2) ? 6 : 4;
      dv = (sel == 4) ? w[4] : (sel == 5) ? w[5] : 1'b1;
      g = (int'(w) >> (16 - gw)) << (12 - gw);
      o = int'(w) % (1 << ow);
      if (o >= (1 << (ow - 1))) o -= 1 << ow;
      if (ctl[11]) g = int'(defc[27:16]);
      if (ctl[10]) o = int'(defc[5:0]) - (defc[5] ? 64 : 0);
      s = int'(a) + o;
      f = (s < 0 || s > 1023);
      s = s < 0 ? 0 : s > 1023 ? 1023 : s;
      p = (s * g) >> 11;
      f = f | (p > 1023);
      p = p > 1023 ? 1023 : p;
      return {dv, f, 10'(p)};
   endfunction

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_pix(input logic [9:0] got, input logic [9:0] exp);
      chk_word({22'h0, got}, {22'h0, exp});
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge ref_clk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge ref_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk_word({30'h0, r}, {30'h0, er});
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      logic ta, tr;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge ref_clk);
         ta = s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge ref_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      chk_word(d, ed);
      chk_word({30'h0, r}, {30'h0, er});
   endtask

   task automatic set_ctl(input logic [31:0] v);
      axi_wr(8'h00, v | 32'h1000, 2'h0);
      ctl = v | 32'h1000;
   endtask

   task automatic shuffle();
      for (j = 0; j < 3; j++) word[j] <= rnd();
      converter_result <= 10'(rnd());
      @(posedge ref_clk);
   endtask

   // One sample pulse; lat is the pin-to-first-pixel count in cycles
   task automatic run(input int lat, input int np);
      logic [11:0] e[$];
      int sl[$];
      logic [11:0] v, b;
      logic [9:0] last;
      logic bp;
      int k, ne, c, ns;
      for (k = 0; k < np; k++) begin
         v = model(converter_result, word[ctl[6] ? int'(ctl[9:8]) : k]);
         if (v[11]) begin
            e.push_back(v);
            sl.push_back(k);
         end
      end
      ne = e.size();
      last = (ctl[4] && ne > 0) ? e[ne - 1][9:0] : v[9:0];
      bp = 1'b0;
      c = 0;
      ns = 0;
      @(posedge ref_clk);
      video_sample_pulse <= 1'b1;
      for (k = 0; k < 44; k++) begin
         @(negedge ref_clk);
         if (bp)
            chk_pix(pixel_out_bus, {b[1:0], 5'h0, b[10], 2'h0});
         bp = 1'b0;
         if (conv_strobe === 1'b1) begin
            chk_word(k, 3 + 2 * ns);
            chk_pix(10'(conv_channel), 10'(ctl[6] ? ctl[9:8] : ns));
            ns++;
         end
         if (pixel_valid_strobe === 1'b1) begin
            b = e.pop_front();
            chk_word(k, lat + 2 * sl.pop_front());
            if (ctl[5])
               chk_pix(pixel_out_bus, {b[9:2], 2'h0});
            else
               chk_pix(pixel_out_bus, b[9:0]);
            chk_word(32'(out_of_range_flag), 32'(b[10]));
            bp = ctl[5];
            c++;
         end
         @(posedge ref_clk);
         video_sample_pulse <= 1'b0;
      end
      chk_word(c, ne);
      chk_word(ns, ctl[7] ? 1 : 3);
      if (!ctl[5])
         chk_pix(pixel_out_bus, last);
   endtask

   task automatic results();
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole run needs about 2000 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 12000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      axi_rd(8'h00, 32'h0000_1000, 2'h0);
      axi_rd(8'h04, 32'h0800_0000, 2'h0);
      axi_rd(8'h0c, 32'h0, 2'h2);
      axi_wr(8'h0c, 32'h1, 2'h2);
      chk_word({31'h0, cds_enable}, 32'h1);
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         shuffle();
         run(23, 3);
      end
      $display("test pass-through done");
      set_ctl(32'h1);
      for (i = 0; i < 10; i++) begin
         for (j = 0; j < 3; j++) word[j] <= 16'(tpsc[i] * 16 + (tpoc[i] & 15));
         converter_result <= 10'(tadc[i]);
         @(posedge ref_clk);
         run(23, 3);
      end
      ev = model(converter_result, word[2]);
      axi_rd(8'h08, {19'h0, 2'h2, ev[10:0]}, 2'h0);
      $display("test table cases done");
      for (i = 0; i < 15; i++) begin
         set_ctl(32'h1 | ((sels[i / 3] & 3) << 2) | ((sels[i / 3] >> 2) << 1));
         shuffle();
         run(23, 3);
      end
      $display("test partitions done");
      word[0] <= rnd() & 16'hffef;
      word[1] <= rnd() | 16'h0010;
      word[2] <= rnd() & 16'hffef;
      for (i = 0; i < 2; i++) begin
         set_ctl(32'h3 | (i << 4));
         run(23, 3);
      end
      $display("test hold done");
      defc = {4'h0, 12'(rnd()), 10'h0, 6'(rnd())};
      axi_wr(8'h04, defc, 2'h0);
      axi_rd(8'h04, defc, 2'h0);
      set_ctl(32'hc01);
      shuffle();
      run(23, 3);
      $display("test defaults done");
      for (i = 0; i < 2; i++) begin
         set_ctl(32'h20 | i);
         shuffle();
         run(23, 3);
      end
      $display("test byte mode done");
      for (i = 0; i < 3; i++) begin
         set_ctl(32'h41 | (i << 8));
         shuffle();
         run(23, 3);
         set_ctl(32'hc1 | (i << 8));
         run(32, 1);
      end
      $display("test monochrome done");
      results();
   end
endmodule
